// ==== rtl/acc_map.svh ====
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_REF_HZ 10000000
`define ACC_CONV_HZ 500000
`define ACC_CONV_DIV (`ACC_REF_HZ / `ACC_CONV_HZ)
`define ACC_CMD_WCFG 8'h44
`define ACC_CMD_RCFG 8'h46
`define ACC_CMD_RDAT 7'h20
`define ACC_CMD_START 4'hC
`define ACC_CFG0_RST 8'h00
`define ACC_CFG1_RST 8'h0A
`define ACC_F_REF 4
`define ACC_F_DIFF 5
`define ACC_F_RUN 6
`define ACC_F_TRIG 7
`define ACC_F_JUST 2
`define ACC_F_PWR 3
`define ACC_FIFO_W 16
`define ACC_FIFO_D 32
`endif

// ==== rtl/acc_pkg.sv ====
package acc_pkg;
    typedef enum logic {ACC_IDLE, ACC_CONV} acc_state_t;
    typedef logic [1:0] acc_res_t;
endpackage : acc_pkg

// ==== rtl/acc_top.sv ====
// Function
// RQ1 - Resolution field picks 6, 8, 10 or 12 bits; default 10.
// RQ2 - Differential mode: input zero inverting, inputs one to three non-inverting.
// RQ3 - Reference bit 1 selects external reference pin, 0 internal bandgap.
// RQ4 - Channel from start command operand, else from input select field.
// RQ5 - Select top bit set samples supply third with bandgap reference always.
// RQ6 - Result placed in 16-bit register, justify bit chooses top or bottom.
// RQ7 - Single-ended code is ratio times 2^N; differential is offset binary.
// RQ8 - Overrange flag updated after every conversion.
// RQ9 - Power bit cleared switches converter off; no conversions occur.
// RQ10 - Start by trigger rising or command; begin after chip select high.
// RQ11 - Run bit low: one conversion per start, done pulse on store.
// RQ12 - Trigger low or new start command aborts running conversion.
// RQ13 - Single conversion takes N/2 plus 3 converter clock cycles; the code stores the result N/2 plus 2 cycles after sampling starts.
// RQ14 - Run bit high: convert repeatedly, done pulse per stored value.
// RQ15 - Continuous interval between results is N/2 plus 1 cycles.
// RQ16 - Sequencing runs on a 500 kHz converter clock.
// RQ17 - Start command byte is 1100 followed by channel select.
// RQ18 - Done pulse lasts one converter clock cycle with the update.
`include "acc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module acc_fifo #(
    parameter int W = `ACC_FIFO_W,
    parameter int D = `ACC_FIFO_D
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [W-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [W-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    always_comb
    begin
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        wr_nxt = push ? wr_r + 1'b1 : wr_r;
        rd_nxt = pop ? rd_r + 1'b1 : rd_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push)
        begin
            mem_r[wr_r] <= in_data_in;
        end
    end

    assign in_ready_out = (cnt_r != (AW+1)'(D));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out = mem_r[rd_r];
endmodule : acc_fifo

module acc_top (
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic PORT_CSN_IN,
    input wire logic PORT_SCK_IN,
    input wire logic PORT_MOSI_IN,
    output logic PORT_MISO_OUT,
    input wire logic [12:0] AFE_CODE_IN,
    output logic AFE_POWER_OUT,
    output logic [2:0] AFE_CHAN_OUT,
    output logic AFE_REF_EXT_OUT,
    output logic AFE_DIFF_OUT,
    output logic AFE_SAMPLE_OUT,
    output logic DONE_OUT,
    output logic [15:0] RESULT_DATA_OUT,
    output logic RESULT_VALID_OUT,
    input wire logic RESULT_READY_IN
);
    import acc_pkg::*;

    localparam logic [4:0] DIV_M1 = 5'(`ACC_CONV_DIV - 1);

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    logic [2:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [7:0] shin_r, shin_nxt, shout_r, shout_nxt, cmd_r, cmd_nxt;
    logic [7:0] cfg0_r, cfg0_nxt, cfg1_r, cfg1_nxt, rx;
    logic sck_rise, sck_fall, frame_go, start_cmd;
    logic trig_rise, trig_fall;
    acc_state_t st_r, st_nxt;
    logic ovr_r, ovr_nxt;
    logic [15:0] data_r, data_nxt;
    logic [4:0] done_r, done_nxt;

    always_comb
    begin
        // The pins are settled once two later stages agree.
        pin_nxt = pin_r;
        for (int i = 0; i < 3; i++)
        begin
            if (s2_r[i] == s3_r[i])
            begin
                pin_nxt[i] = s3_r[i];
            end
        end
        sck_rise = !pin_r[1] && pin_nxt[1] && !pin_r[2];
        sck_fall = pin_r[1] && !pin_nxt[1] && !pin_r[2];
        frame_go = pin_r[2] && !pin_nxt[2];
        bit_nxt = bit_r;
        idx_nxt = idx_r;
        shin_nxt = shin_r;
        shout_nxt = shout_r;
        cmd_nxt = cmd_r;
        cfg0_nxt = cfg0_r;
        cfg1_nxt = cfg1_r;
        start_cmd = 1'b0;
        rx = {shin_r[6:0], pin_r[0]};
        if (frame_go)
        begin
            bit_nxt = 3'h0;
            idx_nxt = 2'h0;
            shout_nxt = {5'h00, st_r == ACC_CONV, ovr_r, done_r != 5'h00};
        end
        else if (sck_fall && bit_r != 3'h0)
        begin
            shout_nxt = {shout_r[6:0], 1'b0};
        end
        else if (sck_rise)
        begin
            shin_nxt = rx;
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7)
            begin
                idx_nxt = (idx_r == 2'h3) ? idx_r : idx_r + 2'h1;
                shout_nxt = 8'h00;
                if (idx_r == 2'h0)
                begin
                    cmd_nxt = rx;
                    start_cmd = (rx[7:4] == `ACC_CMD_START); // [RQ17]
                    if (rx == `ACC_CMD_RCFG)
                    begin
                        shout_nxt = cfg0_r;
                    end
                    else if (rx[7:1] == `ACC_CMD_RDAT)
                    begin
                        shout_nxt = rx[0] ? data_r[15:8] : data_r[7:0];
                    end
                end
                else if (cmd_r == `ACC_CMD_WCFG)
                begin
                    // Bytes after the second configuration byte are reserved and dropped.
                    if (idx_r == 2'h1)
                    begin
                        cfg0_nxt = rx;
                    end
                    else if (idx_r == 2'h2)
                    begin
                        cfg1_nxt = rx;
                    end
                end
                else if (idx_r == 2'h1 && cmd_r == `ACC_CMD_RCFG)
                begin
                    shout_nxt = cfg1_r;
                end
                else if (idx_r == 2'h1 && cmd_r == {`ACC_CMD_RDAT, 1'b0})
                begin
                    shout_nxt = data_r[15:8];
                end
            end
        end
        trig_rise = !cfg0_r[`ACC_F_TRIG] && cfg0_nxt[`ACC_F_TRIG]; // [RQ10]
        trig_fall = cfg0_r[`ACC_F_TRIG] && !cfg0_nxt[`ACC_F_TRIG];
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            // Serial clock resets to its idle low level, so no false edge.
            s1_r <= 3'h5;
            s2_r <= 3'h5;
            s3_r <= 3'h5;
            pin_r <= 3'h5;
            bit_r <= 3'h0;
            idx_r <= 2'h0;
            shin_r <= 8'h00;
            shout_r <= 8'h00;
            cmd_r <= 8'h00;
            cfg0_r <= `ACC_CFG0_RST;
            cfg1_r <= `ACC_CFG1_RST; // [RQ1]
        end
        else
        begin
            s1_r <= {PORT_CSN_IN, PORT_SCK_IN, PORT_MOSI_IN};
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
            bit_r <= bit_nxt;
            idx_r <= idx_nxt;
            shin_r <= shin_nxt;
            shout_r <= shout_nxt;
            cmd_r <= cmd_nxt;
            cfg0_r <= cfg0_nxt;
            cfg1_r <= cfg1_nxt;
        end
    end

    assign PORT_MISO_OUT = shout_r[7];

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    logic [4:0] div_r, div_nxt, n;
    logic [3:0] cnt_r, cnt_nxt, sh, tconv, pch_r, pch_nxt, ch_r, ch_nxt;
    logic pend_r, pend_nxt, smp_r, smp_nxt, ce, pwr, go, fin_try, fin;
    logic fifo_rdy, ovr_c;
    logic [12:0] mask, code_s, sd;
    logic [13:0] t;
    logic [11:0] val;
    logic [15:0] res16;

    always_comb
    begin
        pwr = cfg1_r[`ACC_F_PWR];
        ce = (div_r == DIV_M1); // [RQ16]
        div_nxt = ce ? 5'h00 : div_r + 5'h01;
        n = {2'b00, cfg1_r[1:0], 1'b0} + 5'h06; // [RQ1]
        sh = 4'h6 - {1'b0, cfg1_r[1:0], 1'b0};
        tconv = {2'b00, cfg1_r[1:0]} + 4'h6; // [RQ13]
        mask = (13'h0001 << n) - 13'h0001;
        // Single-ended: plain scaling, saturating on overrange.
        code_s = AFE_CODE_IN >> sh;
        // Differential: offset by half scale and clip both ends.
        sd = 13'($signed(AFE_CODE_IN) >>> sh);
        t = {sd[12], sd} + 14'(14'h0001 << (n - 5'h01)); // [RQ7]
        if (cfg0_r[`ACC_F_DIFF] && !ch_r[3])
        begin
            ovr_c = t[13] || (t > {1'b0, mask});
            val = t[13] ? 12'h000 : (ovr_c ? mask[11:0] : t[11:0]);
        end
        else
        begin
            ovr_c = AFE_CODE_IN[12];
            val = ovr_c ? mask[11:0] : code_s[11:0]; // [RQ7]
        end
        res16 = cfg1_r[`ACC_F_JUST] ? {4'h0, val}
            : 16'({4'h0, val} << (5'h10 - n)); // [RQ6]
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        pch_nxt = pch_r;
        ch_nxt = ch_r;
        smp_nxt = smp_r && !ce;
        ovr_nxt = ovr_r;
        data_nxt = data_r;
        done_nxt = (done_r != 5'h00) ? done_r - 5'h01 : 5'h00;
        go = 1'b0;
        fin_try = 1'b0;
        fin = 1'b0;
        if (start_cmd)
        begin
            pend_nxt = 1'b1;
            pch_nxt = rx[3:0]; // [RQ4]
            st_nxt = ACC_IDLE; // [RQ12]
        end
        else if (trig_rise)
        begin
            pend_nxt = 1'b1;
            pch_nxt = cfg0_r[3:0]; // [RQ4]
        end
        else if (trig_fall)
        begin
            pend_nxt = 1'b0;
            st_nxt = ACC_IDLE; // [RQ12]
        end
        else if (st_r == ACC_IDLE)
        begin
            go = pend_r && pin_r[2] && ce && pwr; // [RQ10]
            if (go)
            begin
                pend_nxt = 1'b0;
                ch_nxt = pch_r;
                smp_nxt = 1'b1;
                cnt_nxt = tconv - 4'h1;
                st_nxt = ACC_CONV;
            end
        end
        else if (ce)
        begin
            fin_try = (cnt_r == 4'h1);
            fin = fin_try && fifo_rdy;
            if (!fin_try)
            begin
                cnt_nxt = cnt_r - 4'h1;
            end
            else if (fin)
            begin
                data_nxt = res16; // [RQ6]
                ovr_nxt = ovr_c; // [RQ8]
                done_nxt = 5'(`ACC_CONV_DIV); // [RQ18]
                smp_nxt = cfg0_r[`ACC_F_RUN];
                cnt_nxt = {2'b00, cfg1_r[1:0]} + 4'h4; // [RQ15]
                // Continuous runs until the run bit drops; else one shot.
                st_nxt = cfg0_r[`ACC_F_RUN] ? ACC_CONV : ACC_IDLE; // [RQ11] [RQ14]
            end
        end
        if (!pwr)
        begin
            st_nxt = ACC_IDLE; // [RQ9]
            pend_nxt = 1'b0;
            smp_nxt = 1'b0;
            done_nxt = 5'h00;
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            div_r <= 5'h00;
            st_r <= ACC_IDLE;
            cnt_r <= 4'h0;
            pend_r <= 1'b0;
            pch_r <= 4'h0;
            ch_r <= 4'h0;
            smp_r <= 1'b0;
            ovr_r <= 1'b0;
            data_r <= 16'h0000;
            done_r <= 5'h00;
        end
        else
        begin
            div_r <= div_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            pch_r <= pch_nxt;
            ch_r <= ch_nxt;
            smp_r <= smp_nxt;
            ovr_r <= ovr_nxt;
            data_r <= data_nxt;
            done_r <= done_nxt;
        end
    end

    assign AFE_POWER_OUT = pwr;
    assign AFE_CHAN_OUT = ch_r[3] ? 3'h4 : {1'b0, ch_r[1:0]}; // [RQ2] [RQ5]
    assign AFE_REF_EXT_OUT = cfg0_r[`ACC_F_REF] && !ch_r[3]; // [RQ3] [RQ5]
    assign AFE_DIFF_OUT = cfg0_r[`ACC_F_DIFF] && !ch_r[3]; // [RQ2]
    assign AFE_SAMPLE_OUT = smp_r;
    assign DONE_OUT = (done_r != 5'h00);

    // Results stall at the last step if the stream consumer lags.
    acc_fifo #(.W(`ACC_FIFO_W), .D(`ACC_FIFO_D)) u_fifo (
        .clk_in(REF_CLK_IN),
        .rstn_in(RESETN_IN),
        .in_data_in(res16),
        .in_valid_in(fin_try),
        .in_ready_out(fifo_rdy),
        .out_data_out(RESULT_DATA_OUT),
        .out_valid_out(RESULT_VALID_OUT),
        .out_ready_in(RESULT_READY_IN)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [4:0] edges_r;
    logic first_r;
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RESETN_IN || go || st_r == ACC_IDLE)
        begin
            edges_r <= 5'h00;
            first_r <= 1'b1;
        end
        else if (fin)
        begin
            edges_r <= 5'h00;
            first_r <= 1'b0;
        end
        else if (ce && !fin_try)
        begin
            edges_r <= edges_r + 5'h01;
        end
    end

    done_width_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ18]
        $rose(DONE_OUT) |-> ##19 DONE_OUT ##1 !DONE_OUT)
        else $error("done pulse width wrong");
    done_src_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ11]
        $rose(DONE_OUT) |-> $past(st_r) == ACC_CONV && data_r == $past(res16))
        else $error("done without a stored result");
    power_off_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ9]
        !pwr |=> st_r == ACC_IDLE && !DONE_OUT [*1])
        else $error("converter active while powered off");
    first_len_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ13]
        fin && first_r |-> edges_r == 5'(tconv - 4'h2))
        else $error("single conversion length wrong");
    cycle_len_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ15]
        fin && !first_r |-> edges_r == {3'h0, cfg1_r[1:0]} + 5'h03)
        else $error("continuous interval wrong");
    abort_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ12]
        trig_fall |=> st_r == ACC_IDLE && !pend_r)
        else $error("trigger low did not abort");
    ovr_upd_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ8]
        fin |=> ovr_r == $past(ovr_c))
        else $error("overrange flag not updated");
    right_just_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ6]
        fin && cfg1_r[`ACC_F_JUST] |=> (data_r >> $past(n)) == 16'h0000)
        else $error("right justified result has high bits");
    wait_csn_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN) // [RQ10]
        $rose(AFE_SAMPLE_OUT) && $past(st_r) == ACC_IDLE
        |-> $past(pin_r[2]) && $past(ce))
        else $error("conversion began inside a port frame");
endmodule : acc_top

`default_nettype wire

// ==== bench/acc_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Register port master
// ----------------------------------------
module acc_host (
    input wire logic clk_in,
    output logic csn_out,
    output logic sck_out,
    output logic mosi_out,
    input wire logic miso_in
);
    // Select idles high and the serial clock stands low between frames.
    initial
    begin
        csn_out = 1'b1;
        sck_out = 1'b0;
        mosi_out = 1'b0;
    end

    // Half periods of six clocks leave room for the port's input sync.
    // Sends nbits of tx top bit first; a start command's conversion only
    // begins once select rises again, so every frame ends by releasing it.
    task automatic frame(input int nbits, input logic [23:0] tx,
        output logic [23:0] rx);
        rx = 24'h0;
        repeat (6) @(posedge clk_in);
        csn_out <= 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            mosi_out <= tx[i];
            repeat (6) @(posedge clk_in);
            rx = {rx[22:0], miso_in};
            sck_out <= 1'b1;
            repeat (6) @(posedge clk_in);
            sck_out <= 1'b0;
        end
        repeat (6) @(posedge clk_in);
        csn_out <= 1'b1;
        mosi_out <= ~tx[0];
    endtask : frame
endmodule : acc_host

`default_nettype wire

// ==== bench/test_adc_conversion_control.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Testbench
// ----------------------------------------
module test_adc_conversion_control;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic ready = 1'b0;
    logic [12:0] code = 13'h0;
    logic csn, sck, mosi, miso, pwr, rext, diff, smp, done, valid;
    logic [2:0] chan;
    logic [15:0] data;
    logic [23:0] rx;
    int errors = 0;
    int compares = 0;

    always #50 ref_clk = ~ref_clk;

    acc_host host (.clk_in(ref_clk), .csn_out(csn), .sck_out(sck),
        .mosi_out(mosi), .miso_in(miso));

    acc_top dut (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn),
        .PORT_CSN_IN(csn), .PORT_SCK_IN(sck), .PORT_MOSI_IN(mosi),
        .PORT_MISO_OUT(miso), .AFE_CODE_IN(code), .AFE_POWER_OUT(pwr),
        .AFE_CHAN_OUT(chan), .AFE_REF_EXT_OUT(rext), .AFE_DIFF_OUT(diff),
        .AFE_SAMPLE_OUT(smp), .DONE_OUT(done), .RESULT_DATA_OUT(data),
        .RESULT_VALID_OUT(valid), .RESULT_READY_IN(ready));

    task automatic chk(input string nm, input logic [15:0] s,
        input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic summarize;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // Counts clocks until s reads v; a hang ends the run.
    task automatic hold(ref logic s, input logic v, output int t);
        t = 0;
        while (s !== v && t < 4000)
        begin
            @(negedge ref_clk);
            t++;
        end
        if (t == 4000)
        begin
            errors++;
            summarize;
        end
    endtask : hold

    task automatic pop;
        @(posedge ref_clk);
        ready <= 1'b1;
        @(posedge ref_clk);
        ready <= 1'b0;
        @(negedge ref_clk);
    endtask : pop

    task automatic quiet(input string nm);
        int k;
        k = 0;
        repeat (400)
        begin
            @(negedge ref_clk);
            k += done;
        end
        chk(nm, k[15:0], 16'h0);
    endtask : quiet

    task automatic conv(input logic [1:0] rs, input logic j,
        input logic df, input logic [3:0] ch, input logic [12:0] cd);
        int n;
        int t;
        logic ok;
        logic [15:0] e;
        n = 6 + 2 * rs;
        e = (cd[11:0] >> (12 - n)) ^ ({15'h0, df} << (n - 1));
        if (!j)
            e = e << (16 - n);
        ok = !(cd[12] & ~df);
        @(posedge ref_clk);
        code <= cd;
        host.frame(24, {8'h44, 2'b00, df, 1'b1, 4'h0, 4'h0, 1'b1, j, rs},
            rx);
        host.frame(8, {16'h0, 4'hC, ch}, rx);
        hold(smp, 1'b1, t);
        chk("chan", {13'h0, chan}, ch[3] ? 16'h4 : {13'h0, ch[2:0]});
        chk("ref", {15'h0, rext}, {15'h0, ~ch[3]});
        chk("diff", {15'h0, diff}, {15'h0, df});
        hold(done, 1'b1, t);
        chk("tconv", {15'h0, t >= (n / 2 + 2) * 20 && t <= (n / 2 + 2) * 20 + 2}, 16'h1);
        if (ok)
            chk("data", data, e);
        hold(done, 1'b0, t);
        chk("pulse", t[15:0], 16'h14);
        host.frame(24, 24'h400000, rx);
        if (ok)
            chk("read", {rx[7:0], rx[15:8]}, e);
        chk("flag", {15'h0, rx[17]}, {15'h0, cd[12] & ~df});
        pop;
        chk("single", {15'h0, valid}, 16'h0);
        $display("test conv done");
    endtask : conv

    task automatic cont;
        int t;
        int h;
        host.frame(24, 24'h444008, rx);
        host.frame(24, 24'h44C008, rx);
        hold(done, 1'b1, t);
        hold(done, 1'b0, h);
        hold(done, 1'b1, t);
        chk("cycle", t[15:0] + h[15:0], 16'h50);
        repeat (3000) @(posedge ref_clk);
        host.frame(24, 24'h440008, rx);
        t = 0;
        while (valid === 1'b1 && t < 40)
        begin
            pop;
            t++;
        end
        chk("depth", t[15:0], 16'h20);
        quiet("abort");
        $display("test cont done");
    endtask : cont

    task automatic power_off;
        host.frame(24, 24'h440002, rx);
        chk("power", {15'h0, pwr}, 16'h0);
        host.frame(8, 24'h0000C0, rx);
        quiet("off");
        host.frame(24, 24'h44000A, rx);
        $display("test power done");
    endtask : power_off

    initial
    begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        host.frame(24, 24'h460000, rx);
        chk("cfg", rx[15:0], 16'h000A);
        chk("pwr", {15'h0, pwr}, 16'h1);
        $display("test reset done");
        for (int r = 0; r < 4; r++)
            conv(r[1:0], r[0], 1'b0, r[3:0], 13'h0ABC);
        conv(2'b10, 1'b1, 1'b0, 4'h8, 13'h0555);
        conv(2'b10, 1'b0, 1'b1, 4'h1, 13'h1F00);
        conv(2'b11, 1'b0, 1'b0, 4'h3, 13'h1000);
        cont;
        power_off;
        summarize;
    end
endmodule : test_adc_conversion_control

`default_nettype wire
